// ===== logic/tcf_pkg.sv
// Constants and state layout for the timer compare, force and counter block.
// Assumes byte offsets on an 8-bit register address; word registers sit at even offsets.
package tcf_pkg;

  localparam int unsigned CH_NUM = 4;

  // Register offsets
  localparam logic [7:0] OFF_SELECT   = 8'hC0;
  localparam logic [7:0] OFF_FORCE    = 8'hC1;
  localparam logic [7:0] OFF_MASK     = 8'hC2;
  localparam logic [7:0] OFF_DATA     = 8'hC3;
  localparam logic [7:0] OFF_COUNTER  = 8'hC4;
  localparam logic [7:0] OFF_SYSCTL   = 8'hC6;
  localparam logic [7:0] OFF_TOGGLE   = 8'hC7;
  localparam logic [7:0] OFF_ACTION   = 8'hC8;
  localparam logic [7:0] OFF_CHIEN    = 8'hCA;
  localparam logic [7:0] OFF_WRAPIEN  = 8'hCB;
  localparam logic [7:0] OFF_CHFLAG   = 8'hCC;
  localparam logic [7:0] OFF_WRAPFLAG = 8'hCD;
  localparam logic [7:0] OFF_VALUE0   = 8'hCE;
  localparam logic [7:0] VALUE_STRIDE = 8'h02;

  // Field positions
  localparam int unsigned POS_TIMER_RUN   = 7;
  localparam int unsigned POS_QUICK_CLEAR = 4;
  localparam int unsigned POS_WRAP_FLAG   = 7;
  localparam int unsigned POS_WRAP_IEN    = 7;

  // Values after reset, counter limit and step, synchroniser fill constants
  localparam logic [3:0]  RST_NIBBLE  = 4'h0;
  localparam logic [7:0]  RST_ACTION  = 8'h00;
  localparam logic [15:0] RST_COUNTER = 16'h0000;
  localparam logic [15:0] RST_VALUE   = 16'h0000;
  localparam logic [15:0] COUNT_TOP   = 16'hFFFF;
  localparam logic [15:0] COUNT_STEP  = 16'h0001;
  localparam logic [2:0]  RST_FILL       = 3'h0;
  localparam logic [2:0]  SYNC_FILL_DONE = 3'h4;
  localparam logic [2:0]  SYNC_FILL_STEP = 3'h1;

  // Output action codes
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_LOW    = 2'h2;
  localparam logic [1:0] ACT_HIGH   = 2'h3;

  typedef struct packed {
    logic [3:0]       channelFunctionSelect;
    logic [3:0]       overrideMaskBit;
    logic [3:0]       overrideDataBit;
    logic [3:0]       overflowToggleBit;
    logic [7:0]       outputAction;
    logic [3:0]       chanIntEnable;
    logic             wrapIntEnable;
    logic             timerRun;
    logic             quickFlagClear;
    logic [15:0]      counter;
    logic [3:0]       channelEventFlag;
    logic             wrapFlag;
    logic [3:0][15:0] channelValue;
    logic [3:0]       pinSync1;
    logic [3:0]       pinSync2;
    logic [3:0]       pinSync3;
    logic [3:0]       pinLevel;
    logic [2:0]       syncFill;
    logic [3:0]       pinOut;
    logic [3:0]       pinOe;
    logic             irq;
    logic [15:0]      rdData;
  } tcf_state_s;

endpackage

// ===== logic/tcf_timer.sv
// Four-channel 16-bit timer: capture, compare, forced compare, channel-3 override,
// toggle on overflow, fast flag clearing and a level interrupt.
// Assumes a register port with one-cycle strobes and a same-clock special-mode level.
`timescale 1ns/1ps

module tcf_timer
  import tcf_pkg::*;
(
  input  wire logic        sys_clk,     // 125 MHz clock
  input  wire logic        rst_n,       // Synchronous reset, active low
  input  wire logic [7:0]  busAddr,     // Register byte offset
  input  wire logic [15:0] busWdata,    // Write data, bytes in low lane
  input  wire logic        busWrite,    // Write strobe
  input  wire logic        busRead,     // Read strobe
  input  wire logic        specialMode, // High in special operating modes
  input  wire logic [3:0]  pinIn,       // Channel pin levels from the port
  output logic      [15:0] busRdata,    // Read data, cycle after the strobe
  output logic      [3:0]  pinOut,      // Channel pin output values
  output logic      [3:0]  pinOe,       // Channel pin output enables
  output logic             irq          // Level interrupt
);

  tcf_state_s s_r;
  tcf_state_s s_nxt;

  logic [3:0] matchNow;
  logic [3:0] forceNow;
  logic [3:0] captureEdge;
  logic       wrapNow;
  logic       ch3Event;

  function automatic logic apply_action(input logic [1:0] code, input logic cur);
    logic res;
    res = cur;
    case (code)
      ACT_NONE:   res = cur;
      ACT_TOGGLE: res = ~cur;
      ACT_LOW:    res = 1'b0;
      ACT_HIGH:   res = 1'b1;
      default:    res = cur;
    endcase
    return res;
  endfunction

  function automatic logic [7:0] value_addr(input int unsigned idx);
    return OFF_VALUE0 + VALUE_STRIDE * 8'(idx);
  endfunction

  // Event terms shared by the next-state logic and the checks
  always_comb begin
    wrapNow  = s_r.timerRun && (s_r.counter == COUNT_TOP);
    forceNow = (busWrite && busAddr == OFF_FORCE) ? busWdata[3:0] : 4'h0;
    for (int i = 0; i < CH_NUM; i++) begin
      matchNow[i]    = s_r.timerRun && s_r.channelFunctionSelect[i]
                       && (s_r.counter == s_r.channelValue[i]);
      // No capture until the chain holds real pin samples, so an idle-high pin
      // does not look like an edge straight after reset
      captureEdge[i] = !s_r.channelFunctionSelect[i] && (s_r.syncFill == SYNC_FILL_DONE)
                       && (s_r.pinSync2[i] == s_r.pinSync3[i])
                       && (s_r.pinSync3[i] != s_r.pinLevel[i]);
    end
    ch3Event = s_r.channelFunctionSelect[3] && (matchNow[3] || forceNow[3]);
  end

  always_comb begin
    logic       p;
    logic       clr;
    logic       quick;
    logic [1:0] code;
    logic [15:0] rv;
    p     = 1'b0;
    clr   = 1'b0;
    quick = 1'b0;
    code  = ACT_NONE;
    rv    = 16'h0000;
    s_nxt = s_r;

    // Three-stage pin synchroniser; a level counts once stages two and three agree
    s_nxt.pinSync1 = pinIn;
    s_nxt.pinSync2 = s_r.pinSync1;
    s_nxt.pinSync3 = s_r.pinSync2;
    // Counts the edges since reset until the chain has filled
    if (s_r.syncFill != SYNC_FILL_DONE) begin
      s_nxt.syncFill = s_r.syncFill + SYNC_FILL_STEP;
    end
    for (int i = 0; i < CH_NUM; i++) begin
      if (s_r.pinSync2[i] == s_r.pinSync3[i]) begin
        s_nxt.pinLevel[i] = s_r.pinSync3[i];
      end
    end

    // Counter: runs only while enabled, wraps from all ones
    if (s_r.timerRun) begin
      s_nxt.counter = s_r.counter + COUNT_STEP;
    end
    if (busWrite && busAddr == OFF_COUNTER && specialMode) begin
      s_nxt.counter = busWdata;
    end

    // Plain control registers
    if (busWrite) begin
      case (busAddr)
        OFF_SELECT:  s_nxt.channelFunctionSelect = busWdata[3:0];
        OFF_MASK:    s_nxt.overrideMaskBit       = busWdata[3:0];
        OFF_DATA:    s_nxt.overrideDataBit       = busWdata[3:0];
        OFF_TOGGLE:  s_nxt.overflowToggleBit     = busWdata[3:0];
        OFF_ACTION:  s_nxt.outputAction          = busWdata[7:0];
        OFF_CHIEN:   s_nxt.chanIntEnable         = busWdata[3:0];
        OFF_WRAPIEN: s_nxt.wrapIntEnable         = busWdata[POS_WRAP_IEN];
        OFF_SYSCTL: begin
          s_nxt.timerRun       = busWdata[POS_TIMER_RUN];
          s_nxt.quickFlagClear = busWdata[POS_QUICK_CLEAR];
        end
        default: ;
      endcase
    end

    for (int i = 0; i < CH_NUM; i++) begin
      code = s_r.outputAction[2*i +: 2];
      p    = s_r.pinOut[i];
      if (s_r.channelFunctionSelect[i]) begin
        // Later assignments carry higher priority
        if (matchNow[i]) begin
          p = apply_action(code, s_r.pinOut[i]);
        end
        if (forceNow[i]) begin
          p = apply_action(code, s_r.pinOut[i]);
        end
        if (ch3Event && s_r.overrideMaskBit[i]) begin
          p = s_r.overrideDataBit[i];
        end
        if (wrapNow && s_r.overflowToggleBit[i]) begin
          p = ~s_r.pinOut[i];
        end
      end
      s_nxt.pinOut[i] = p;
      s_nxt.pinOe[i]  = s_nxt.channelFunctionSelect[i]
                        && (s_nxt.overrideMaskBit[i] || s_nxt.outputAction[2*i +: 2] != ACT_NONE);

      // Value register: capture on edge, software write only in compare mode
      if (captureEdge[i]) begin
        s_nxt.channelValue[i] = s_r.counter;
      end else if (busWrite && busAddr == value_addr(i) && s_r.channelFunctionSelect[i]) begin
        s_nxt.channelValue[i] = busWdata;
      end

      // Flag clear: quick clear by value access, else write one to clear
      quick = s_r.quickFlagClear && busAddr == value_addr(i)
              && ((busRead && !s_r.channelFunctionSelect[i])
                  || (busWrite && s_r.channelFunctionSelect[i]));
      clr   = (!s_r.quickFlagClear && busWrite && busAddr == OFF_CHFLAG && busWdata[i]) || quick;
      // Set wins over clear; a forced compare never sets the flag
      s_nxt.channelEventFlag[i] = (matchNow[i] && !forceNow[i]) || captureEdge[i]
                                  || (s_r.channelEventFlag[i] && !clr);
    end

    // Wrap flag
    quick = s_r.quickFlagClear && busAddr == OFF_COUNTER && (busRead || busWrite);
    clr   = (!s_r.quickFlagClear && busWrite && busAddr == OFF_WRAPFLAG && busWdata[POS_WRAP_FLAG]) || quick;
    s_nxt.wrapFlag = wrapNow || (s_r.wrapFlag && !clr);

    s_nxt.irq = |(s_nxt.channelEventFlag & s_nxt.chanIntEnable) || (s_nxt.wrapFlag && s_nxt.wrapIntEnable);

    // Read data, valid only in the cycle after the strobe
    if (busRead) begin
      case (busAddr)
        OFF_SELECT:   rv = {12'h000, s_r.channelFunctionSelect};
        OFF_FORCE:    rv = 16'h0000;
        OFF_MASK:     rv = {12'h000, s_r.overrideMaskBit};
        OFF_DATA:     rv = {12'h000, s_r.overrideDataBit};
        OFF_COUNTER:  rv = s_r.counter;
        OFF_SYSCTL:   rv = {8'h00, s_r.timerRun, 2'h0, s_r.quickFlagClear, 4'h0};
        OFF_TOGGLE:   rv = {12'h000, s_r.overflowToggleBit};
        OFF_ACTION:   rv = {8'h00, s_r.outputAction};
        OFF_CHIEN:    rv = {12'h000, s_r.chanIntEnable};
        OFF_WRAPIEN:  rv = {8'h00, s_r.wrapIntEnable, 7'h00};
        OFF_CHFLAG:   rv = {12'h000, s_r.channelEventFlag};
        OFF_WRAPFLAG: rv = {8'h00, s_r.wrapFlag, 7'h00};
        default: begin
          for (int i = 0; i < CH_NUM; i++) begin
            if (busAddr == value_addr(i)) begin
              rv = s_r.channelValue[i];
            end
          end
        end
      endcase
    end
    s_nxt.rdData = rv;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_r <= '{channelFunctionSelect: RST_NIBBLE, overrideMaskBit: RST_NIBBLE,
               overrideDataBit: RST_NIBBLE, overflowToggleBit: RST_NIBBLE,
               outputAction: RST_ACTION, chanIntEnable: RST_NIBBLE,
               wrapIntEnable: 1'b0, timerRun: 1'b0, quickFlagClear: 1'b0,
               counter: RST_COUNTER, channelEventFlag: RST_NIBBLE, wrapFlag: 1'b0,
               channelValue: {CH_NUM{RST_VALUE}}, pinSync1: RST_NIBBLE,
               pinSync2: RST_NIBBLE, pinSync3: RST_NIBBLE, pinLevel: RST_NIBBLE, syncFill: RST_FILL,
               pinOut: RST_NIBBLE, pinOe: RST_NIBBLE, irq: 1'b0, rdData: 16'h0000};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busRdata = s_r.rdData;
  assign pinOut   = s_r.pinOut;
  assign pinOe    = s_r.pinOe;
  assign irq      = s_r.irq;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_force_reads_zero;
    busRead && busAddr == OFF_FORCE |=> busRdata == 16'h0000;
  endproperty
  a_force_reads_zero: assert property (p_force_reads_zero) else $error("force register read not zero");

  property p_force_no_flag;
    busWrite && busAddr == OFF_FORCE && busWdata[0] && s_r.channelFunctionSelect[0]
      && !s_r.channelEventFlag[0] |=> !s_r.channelEventFlag[0];
  endproperty
  a_force_no_flag: assert property (p_force_no_flag) else $error("forced compare set a flag");

  property p_override_copy;
    ch3Event && s_r.overrideMaskBit[1] && s_r.channelFunctionSelect[1]
      && !(wrapNow && s_r.overflowToggleBit[1]) |=> pinOut[1] == $past(s_r.overrideDataBit[1]);
  endproperty
  a_override_copy: assert property (p_override_copy) else $error("override data not copied");

  property p_mask_drives;
    s_r.channelFunctionSelect[0] && s_r.overrideMaskBit[0] && !busWrite |=> pinOe[0];
  endproperty
  a_mask_drives: assert property (p_mask_drives) else $error("masked compare pin not driven");

  property p_wrap;
    wrapNow && !(busWrite && busAddr == OFF_COUNTER) |=> s_r.counter == 16'h0000 && s_r.wrapFlag;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter wrap wrong");

  property p_write_ignored;
    s_r.timerRun && busWrite && busAddr == OFF_COUNTER && !specialMode
      |=> s_r.counter == $past(s_r.counter) + 16'h0001;
  endproperty
  a_write_ignored: assert property (p_write_ignored) else $error("counter write took effect");

  property p_stopped;
    !s_r.timerRun && !(busWrite && busAddr == OFF_COUNTER) |=> $stable(s_r.counter);
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped counter moved");

  property p_quick_capture;
    s_r.quickFlagClear && busRead && busAddr == OFF_VALUE0 && !s_r.channelFunctionSelect[0]
      && !captureEdge[0] |=> !s_r.channelEventFlag[0];
  endproperty
  a_quick_capture: assert property (p_quick_capture) else $error("quick clear missed");

  property p_quick_wrap;
    s_r.quickFlagClear && busRead && busAddr == OFF_COUNTER && !wrapNow |=> !s_r.wrapFlag;
  endproperty
  a_quick_wrap: assert property (p_quick_wrap) else $error("wrap flag not cleared");

  property p_toggle;
    wrapNow && s_r.overflowToggleBit[2] && s_r.channelFunctionSelect[2]
      |=> pinOut[2] != $past(pinOut[2]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("overflow toggle missing");

  property p_zero_keeps;
    busWrite && busAddr == OFF_CHFLAG && !busWdata[0] && s_r.channelEventFlag[0]
      |=> s_r.channelEventFlag[0];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("zero write cleared flag");

  property p_force_acts;
    busWrite && busAddr == OFF_FORCE && busWdata[0] && s_r.channelFunctionSelect[0]
      && s_r.outputAction[1:0] == ACT_HIGH && !s_r.overrideMaskBit[0]
      && !s_r.overflowToggleBit[0] |=> pinOut[0];
  endproperty
  a_force_acts: assert property (p_force_acts) else $error("forced action not applied");

  property p_ch3_priority;
    matchNow[0] && ch3Event && s_r.overrideMaskBit[0] && !(wrapNow && s_r.overflowToggleBit[0])
      |=> pinOut[0] == $past(s_r.overrideDataBit[0]);
  endproperty
  a_ch3_priority: assert property (p_ch3_priority) else $error("channel 3 override lost");

  property p_mask_clear;
    s_r.channelFunctionSelect[1] && !s_r.overrideMaskBit[1] && s_r.outputAction[3:2] == ACT_NONE && !busWrite
      |=> !pinOe[1];
  endproperty
  a_mask_clear: assert property (p_mask_clear) else $error("unmasked idle pin driven");

  property p_capture_input;
    !s_r.channelFunctionSelect[2] && !busWrite |=> !pinOe[2];
  endproperty
  a_capture_input: assert property (p_capture_input) else $error("capture pin driven");

  property p_count_step;
    s_r.timerRun && !wrapNow && !(busWrite && busAddr == OFF_COUNTER)
      |=> s_r.counter == $past(s_r.counter) + COUNT_STEP;
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not step");

  property p_special_write;
    busWrite && busAddr == OFF_COUNTER && specialMode |=> s_r.counter == $past(busWdata);
  endproperty
  a_special_write: assert property (p_special_write) else $error("special counter write lost");

  property p_run_bit;
    busWrite && busAddr == OFF_SYSCTL |=> s_r.timerRun == $past(busWdata[POS_TIMER_RUN]);
  endproperty
  a_run_bit: assert property (p_run_bit) else $error("run bit not taken");

  property p_quick_compare;
    s_r.quickFlagClear && busWrite && busAddr == OFF_VALUE0 + VALUE_STRIDE && s_r.channelFunctionSelect[1]
      && !matchNow[1] |=> !s_r.channelEventFlag[1];
  endproperty
  a_quick_compare: assert property (p_quick_compare) else $error("quick clear on write missed");

  property p_quick_wrap_write;
    s_r.quickFlagClear && busWrite && busAddr == OFF_COUNTER && !wrapNow |=> !s_r.wrapFlag;
  endproperty
  a_quick_wrap_write: assert property (p_quick_wrap_write) else $error("wrap flag kept on write");

  property p_toggle_force;
    wrapNow && forceNow[1] && s_r.overflowToggleBit[1] && s_r.channelFunctionSelect[1]
      |=> pinOut[1] != $past(pinOut[1]);
  endproperty
  a_toggle_force: assert property (p_toggle_force) else $error("force beat overflow toggle");

  property p_one_clears;
    !s_r.quickFlagClear && busWrite && busAddr == OFF_WRAPFLAG && busWdata[POS_WRAP_FLAG] && !wrapNow
      |=> !s_r.wrapFlag;
  endproperty
  a_one_clears: assert property (p_one_clears) else $error("write one kept wrap flag");

  property p_action_low;
    matchNow[1] && s_r.outputAction[3:2] == ACT_LOW && !(ch3Event && s_r.overrideMaskBit[1])
      && !(wrapNow && s_r.overflowToggleBit[1]) |=> !pinOut[1];
  endproperty
  a_action_low: assert property (p_action_low) else $error("drive-low action missed");

  property p_capture_load;
    captureEdge[0] |=> s_r.channelEventFlag[0] && s_r.channelValue[0] == $past(s_r.counter);
  endproperty
  a_capture_load: assert property (p_capture_load) else $error("capture not taken");

  property p_no_wrap_stopped;
    !s_r.timerRun && !s_r.wrapFlag && !busWrite |=> !s_r.wrapFlag;
  endproperty
  a_no_wrap_stopped: assert property (p_no_wrap_stopped) else $error("wrap flag set while stopped");

  property p_toggle_compare_only;
    wrapNow && s_r.overflowToggleBit[1] && !s_r.channelFunctionSelect[1]
      |=> pinOut[1] == $past(pinOut[1]);
  endproperty
  a_toggle_compare_only: assert property (p_toggle_compare_only) else $error("capture pin toggled");

endmodule

// ===== dv/tcf_port_model.sv
// Port pin model for the timer channels: each line is driven by the block or by the outside.
// Assumes the bench sets the outside levels; channel 3 is a receive-only line.
`timescale 1ns/1ps

module tcf_port_model (
  input  wire logic [3:0] pinOut,   // Block pin values
  input  wire logic [3:0] pinOe,    // Block pin enables
  input  wire logic [3:0] extLevel, // Outside drive levels
  output logic      [3:0] pinIn     // Resolved pin levels
);
  // Channel 3 has no output path, so it always follows the outside level
  always_comb begin
    pinIn = extLevel;
    for (int i = 0; i < 3; i++) begin
      if (pinOe[i]) begin
        pinIn[i] = pinOut[i];
      end
    end
  end
endmodule

// ===== dv/tcf_timer_tb_top.sv
// Self-checking bench for the timer compare, force and counter block.
// Assumes the register map and one-clock-per-count behaviour of tcf_pkg.
`timescale 1ns/1ps

module tcf_timer_tb_top;
  import tcf_pkg::*;

  logic        sys_clk;
  logic        rst_n;
  logic [7:0]  busAddr;
  logic [15:0] busWdata;
  logic        busWrite;
  logic        busRead;
  logic        specialMode;
  logic [3:0]  extLevel;
  logic [3:0]  pinIn;
  logic [15:0] busRdata;
  logic [3:0]  pinOut;
  logic [3:0]  pinOe;
  logic        irq;
  logic [15:0] rv;
  logic [15:0] rv2;
  int          error_cnt;
  int          check_count;

  tcf_timer dut (.sys_clk(sys_clk), .rst_n(rst_n), .busAddr(busAddr), .busWdata(busWdata),
    .busWrite(busWrite), .busRead(busRead), .specialMode(specialMode), .pinIn(pinIn),
    .busRdata(busRdata), .pinOut(pinOut), .pinOe(pinOe), .irq(irq));
  tcf_port_model port (.pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel), .pinIn(pinIn));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    busAddr  <= a;
    busWdata <= d;
    busWrite <= 1'b1;
    @(posedge sys_clk);
    busWrite <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    busAddr <= a;
    busRead <= 1'b1;
    @(posedge sys_clk);
    busRead <= 1'b0;
    #1;
    d = busRdata;
  endtask

  task automatic rc(input string n, input logic [7:0] a, input logic [15:0] e);
    rd(a, rv);
    chk(n, rv, e);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic mode(input logic m);
    @(posedge sys_clk);
    specialMode <= m;
  endtask

  task automatic test_reset;
    rc("force", OFF_FORCE, 16'h0000);
    rc("mask", OFF_MASK, 16'h0000);
    rc("counter", OFF_COUNTER, 16'h0000);
    rc("toggle", OFF_TOGGLE, 16'h0000);
    rc("unmapped", 8'hF0, 16'h0000);
    $display("test reset done");
  endtask

  task automatic test_counter;
    mode(1'b1);
    wr(OFF_COUNTER, 16'h1234);
    rc("cnt write", OFF_COUNTER, 16'h1234);
    mode(1'b0);
    wr(OFF_COUNTER, 16'hABCD);
    rc("cnt locked", OFF_COUNTER, 16'h1234);
    rc("cnt low byte", OFF_COUNTER + 8'h01, 16'h0000);
    wr(OFF_SYSCTL, 16'h0080);
    rd(OFF_COUNTER, rv);
    rd(OFF_COUNTER, rv2);
    chk("running", rv2 - rv, 16'h0002);
    wr(OFF_COUNTER, 16'h0000);
    rd(OFF_COUNTER, rv);
    chk("cnt run locked", {15'h0, rv > rv2}, 16'h0001);
    wr(OFF_SYSCTL, 16'h0000);
    rd(OFF_COUNTER, rv);
    rd(OFF_COUNTER, rv2);
    chk("stopped", rv2 - rv, 16'h0000);
    $display("test counter done");
  endtask

  task automatic test_force;
    logic [1:0] codes[6] = '{2'h3, 2'h1, 2'h1, 2'h2, 2'h3, 2'h0};
    logic       pins[6]  = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    wr(OFF_SELECT, 16'h0001);
    foreach (codes[i]) begin
      wr(OFF_ACTION, {14'h0, codes[i]});
      wr(OFF_FORCE, 16'h0001);
      idle(1);
      chk("forced pin", {15'h0, pinOut[0]}, {15'h0, pins[i]});
    end
    rc("no flag", OFF_CHFLAG, 16'h0000);
    rc("force reads", OFF_FORCE, 16'h0000);
    $display("test force done");
  endtask

  task automatic test_override;
    wr(OFF_SELECT, 16'h000F);
    wr(OFF_MASK, 16'h0007);
    wr(OFF_DATA, 16'h0005);
    wr(OFF_FORCE, 16'h0008);
    idle(1);
    chk("override pins", {13'h0, pinOut[2:0]}, 16'h0005);
    chk("override oe", {13'h0, pinOe[2:0]}, 16'h0007);
    $display("test override done");
  endtask

  task automatic test_wrap;
    wr(OFF_MASK, 16'h0000);
    wr(OFF_SELECT, 16'h0002);
    wr(OFF_ACTION, 16'h0008);
    wr(OFF_VALUE0 + VALUE_STRIDE, 16'h8000);
    wr(OFF_TOGGLE, 16'h0002);
    wr(OFF_WRAPIEN, 16'h0080);
    mode(1'b1);
    wr(OFF_COUNTER, 16'hFFFE);
    mode(1'b0);
    wr(OFF_SYSCTL, 16'h0080);
    idle(4);
    wr(OFF_SYSCTL, 16'h0000);
    idle(2);
    chk("toggled pin", {15'h0, pinOut[1]}, 16'h0001);
    rc("wrap flag", OFF_WRAPFLAG, 16'h0080);
    chk("irq on", {15'h0, irq}, 16'h0001);
    wr(OFF_WRAPIEN, 16'h0000);
    idle(1);
    chk("irq masked", {15'h0, irq}, 16'h0000);
    wr(OFF_WRAPIEN, 16'h0080);
    wr(OFF_WRAPFLAG, 16'h0000);
    idle(1);
    chk("irq kept", {15'h0, irq}, 16'h0001);
    wr(OFF_WRAPFLAG, 16'h0080);
    idle(1);
    chk("irq cleared", {15'h0, irq}, 16'h0000);
    $display("test wrap done");
  endtask

  task automatic test_quick;
    mode(1'b1);
    wr(OFF_COUNTER, 16'hFFFE);
    wr(OFF_VALUE0 + VALUE_STRIDE, 16'h0001);
    mode(1'b0);
    wr(OFF_SYSCTL, 16'h0090);
    idle(4);
    wr(OFF_SYSCTL, 16'h0010);
    rc("wrap set", OFF_WRAPFLAG, 16'h0080);
    rc("match flag", OFF_CHFLAG, 16'h0002);
    rd(OFF_COUNTER, rv);
    rc("wrap quick", OFF_WRAPFLAG, 16'h0000);
    wr(OFF_VALUE0 + VALUE_STRIDE, 16'h0100);
    rc("flag quick", OFF_CHFLAG, 16'h0000);
    $display("test quick done");
  endtask

  // Channel 0 in capture mode, timer stopped at a known count, quick clear still on
  task automatic test_capture;
    mode(1'b1);
    wr(OFF_COUNTER, 16'h5A5A);
    mode(1'b0);
    @(posedge sys_clk);
    extLevel <= 4'hE;
    idle(6);
    rc("capture flag", OFF_CHFLAG, 16'h0001);
    rc("capture value", OFF_VALUE0, 16'h5A5A);
    rc("capture cleared", OFF_CHFLAG, 16'h0000);
    wr(OFF_VALUE0, 16'h1111);
    rc("capture locked", OFF_VALUE0, 16'h5A5A);
    $display("test capture done");
  endtask

  initial begin
    error_cnt = 0;
    check_count = 0;
    rst_n = 1'b0;
    busAddr = 8'h00;
    busWdata = 16'h0000;
    busWrite = 1'b0;
    busRead = 1'b0;
    specialMode = 1'b0;
    extLevel = 4'hF;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    test_reset();
    test_counter();
    test_force();
    test_override();
    test_wrap();
    test_quick();
    test_capture();
    stop_test();
  end

  // Guard against a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    stop_test();
  end
endmodule
